// >>> hw/can_int_pkg.sv
// Constants, register map and carrier types of the CAN interrupt logic.
// Assumes a single 125 MHz pclk domain and an APB register port.
//
// Function
// - Receive flag set when buffer loaded after frame end
// - Three-bit pending source code, fixed encoding
// - Code terms are flag AND enable, fixed priority
// - Message error flag set on transfer errors
// - Bus activity in sleep with wake enabled sets wake, exits sleep
// - Error flag on overflow or error state change
// - Overflow flag when target buffer still full
// - Receive warning when receive counter reaches 96
// - Transmit warning when transmit counter reaches 96
// - Receive error-passive when receive counter exceeds 127
// - Transmit error-passive when transmit counter exceeds 127
// - Bus-off when transmit counter exceeds 255
// - Interrupt pending while any enabled flag set
// - Clear ignored while its condition persists
// - Transmit flag set when buffer becomes empty
// - Code moves to next source after clear
package can_int_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS   = 8'h00;
    localparam logic [7:0] OFS_ENABLE  = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_COMM    = 8'h0C;
    localparam logic [7:0] OFS_CTRL    = 8'h10;
    localparam logic [7:0] OFS_ERRCNT  = 8'h14;

    // Flag and enable bit positions
    localparam int FLG_RX0  = 0;
    localparam int FLG_RX1  = 1;
    localparam int FLG_TX0  = 2;
    localparam int FLG_TX1  = 3;
    localparam int FLG_TX2  = 4;
    localparam int FLG_ERR  = 5;
    localparam int FLG_WAK  = 6;
    localparam int FLG_MERR = 7;
    localparam int NUM_FLAGS = 8;

    // Communication status bit positions
    localparam int CS_EWARN   = 0;
    localparam int CS_RXWARN  = 1;
    localparam int CS_TXWARN  = 2;
    localparam int CS_RXPASS  = 3;
    localparam int CS_TXPASS  = 4;
    localparam int CS_BUSOFF  = 5;
    localparam int CS_RX1OVF  = 6;
    localparam int CS_RX0OVF  = 7;

    // Status and control bit positions
    localparam int ST_CODE_LSB = 0;
    localparam int ST_IRQ      = 3;
    localparam int ST_SLEEP    = 4;
    localparam int ST_MODE_LSB = 5;
    localparam int CTRL_SLEEP  = 0;
    localparam int ERRCNT_TEC_LSB = 16;

    // Reset values
    localparam logic [7:0] FLAGS_RST  = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [1:0] OVF_RST    = 2'h0;

    // Error counter limits
    localparam int WARN_LIMIT    = 96;
    localparam int PASSIVE_LIMIT = 127;
    localparam int BUSOFF_LIMIT  = 255;

    // Pending source codes
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_ERR  = 3'h1;
    localparam logic [2:0] CODE_TX2  = 3'h2;
    localparam logic [2:0] CODE_TX1  = 3'h3;
    localparam logic [2:0] CODE_TX0  = 3'h4;
    localparam logic [2:0] CODE_RX1  = 3'h5;
    localparam logic [2:0] CODE_RX0  = 3'h6;
    localparam logic [2:0] CODE_WAK  = 3'h7;

    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_PASSIVE,
        MODE_BUSOFF
    } err_mode_t;

    // Events from the protocol engine, one-cycle pulses except bus_activity
    typedef struct packed {
        logic [1:0] rx_load;
        logic [1:0] mab_accept;
        logic [2:0] tx_empty;
        logic       msg_error;
        logic       bus_activity;
    } engine_evt_t;

    // Error state levels derived from the counters
    typedef struct packed {
        logic ewarn;
        logic rx_warn;
        logic tx_warn;
        logic rx_passive;
        logic tx_passive;
        logic bus_off;
    } err_state_t;

endpackage

// >>> hw/err_state_monitor.sv
// Error state monitor: turns the error counters into warning, passive and
// bus-off levels, registered once.
// Assumes counters synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module err_state_monitor
    import can_int_pkg::*;
#(
    parameter int REC_W = 8,
    parameter int TEC_W = 9
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [REC_W-1:0] rx_err_cnt,
    input  wire logic [TEC_W-1:0] tx_err_cnt,
    output var  err_state_t       state_q
);

    initial begin
        if (REC_W < 8 || TEC_W < 9) begin
            $error("Counters too narrow for the error limits");
        end
    end

    err_state_t state_d;

    always_comb begin
        state_d.rx_warn    = int'(rx_err_cnt) >= WARN_LIMIT;
        state_d.tx_warn    = int'(tx_err_cnt) >= WARN_LIMIT;
        state_d.rx_passive = int'(rx_err_cnt) > PASSIVE_LIMIT;
        state_d.tx_passive = int'(tx_err_cnt) > PASSIVE_LIMIT;
        state_d.bus_off    = int'(tx_err_cnt) > BUSOFF_LIMIT;
        state_d.ewarn      = state_d.rx_warn | state_d.tx_warn;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule
`default_nettype wire

// >>> hw/can_interrupt_logic.sv
// CAN interrupt logic: flags, enables, priority code and request line,
// with an APB register port.
// Assumes engine events and counters synchronous to pclk.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module can_interrupt_logic
    import can_int_pkg::*;
#(
    parameter int REC_W = 8,
    parameter int TEC_W = 9
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire engine_evt_t      engine_evt,
    input  wire logic [REC_W-1:0] rx_err_cnt,
    input  wire logic [TEC_W-1:0] tx_err_cnt,
    output logic                  irq,
    output logic      [2:0]       pending_source_code,
    output logic                  sleep_mode,
    output err_mode_t             error_mode
);

    initial begin
        if (REC_W > 16 || TEC_W > 16) begin
            $error("Counters wider than their register fields");
        end
    end

    typedef enum {
        SEL_FLAGS,
        SEL_ENABLE,
        SEL_STATUS,
        SEL_COMM,
        SEL_CTRL,
        SEL_ERRCNT,
        SEL_NONE
    } reg_sel_t;

    function automatic reg_sel_t decode(input logic [7:0] addr);
        case (addr)
            OFS_FLAGS:  decode = SEL_FLAGS;
            OFS_ENABLE: decode = SEL_ENABLE;
            OFS_STATUS: decode = SEL_STATUS;
            OFS_COMM:   decode = SEL_COMM;
            OFS_CTRL:   decode = SEL_CTRL;
            OFS_ERRCNT: decode = SEL_ERRCNT;
            default:    decode = SEL_NONE;
        endcase
    endfunction

    // Fixed priority: error, tx0, tx1, tx2, rx0, rx1, wake
    function automatic logic [2:0] encode(input logic [NUM_FLAGS-1:0] term);
        if (term[FLG_ERR]) begin
            encode = CODE_ERR;
        end else if (term[FLG_TX0]) begin
            encode = CODE_TX0;
        end else if (term[FLG_TX1]) begin
            encode = CODE_TX1;
        end else if (term[FLG_TX2]) begin
            encode = CODE_TX2;
        end else if (term[FLG_RX0]) begin
            encode = CODE_RX0;
        end else if (term[FLG_RX1]) begin
            encode = CODE_RX1;
        end else if (term[FLG_WAK]) begin
            encode = CODE_WAK;
        end else begin
            encode = CODE_NONE;
        end
    endfunction

    logic [NUM_FLAGS-1:0] flags_q;
    logic [NUM_FLAGS-1:0] flags_d;
    logic [NUM_FLAGS-1:0] enable_q;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_hold;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic [NUM_FLAGS-1:0] terms_d;
    logic [1:0]           ovf_q;
    logic [1:0]           ovf_d;
    logic [1:0]           ovf_set;
    logic [1:0]           ovf_clr;
    logic                 sleep_q;
    logic                 wake_evt;
    logic                 state_change;
    err_state_t           err_state;
    err_state_t           err_state_prev_q;
    reg_sel_t             sel;
    logic                 access;
    logic                 wr_commit;
    logic [31:0]          rdata_d;
    logic                 pready_q;
    logic [31:0]          prdata_q;
    logic                 pslverr_q;
    logic                 irq_q;
    logic [2:0]           code_q;
    err_mode_t            mode_q;
    err_mode_t            mode_d;

    err_state_monitor #(
        .REC_W (REC_W),
        .TEC_W (TEC_W)
    ) u_err_state (
        .pclk       (pclk),
        .presetn    (presetn),
        .rx_err_cnt (rx_err_cnt),
        .tx_err_cnt (tx_err_cnt),
        .state_q    (err_state)
    );

    // Bus decode; writes land on the edge that completes the access
    assign sel       = decode(paddr);
    assign access    = psel & penable;
    assign wr_commit = access & pready_q & pwrite;

    // Error state edges, any direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_state_prev_q <= '0;
        end else begin
            err_state_prev_q <= err_state;
        end
    end

    assign state_change = err_state != err_state_prev_q;

    // A message accepted for a buffer whose full flag is still set overflows
    assign ovf_set = engine_evt.mab_accept & {flags_q[FLG_RX1], flags_q[FLG_RX0]};
    assign ovf_clr = (wr_commit && sel == SEL_COMM) ?
                     ~{pwdata[CS_RX1OVF], pwdata[CS_RX0OVF]} : 2'h0;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ovf_d[i] = ovf_q[i];
            if (ovf_clr[i]) begin
                ovf_d[i] = 1'b0;
            end
            if (ovf_set[i]) begin
                ovf_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= OVF_RST;
        end else begin
            ovf_q <= ovf_d;
        end
    end

    // Wake only counts while asleep with the source enabled
    assign wake_evt = sleep_q & enable_q[FLG_WAK] & engine_evt.bus_activity;

    always_comb begin
        flag_set            = '0;
        flag_set[FLG_RX0]   = engine_evt.rx_load[0];
        flag_set[FLG_RX1]   = engine_evt.rx_load[1];
        flag_set[FLG_TX0]   = engine_evt.tx_empty[0];
        flag_set[FLG_TX1]   = engine_evt.tx_empty[1];
        flag_set[FLG_TX2]   = engine_evt.tx_empty[2];
        flag_set[FLG_ERR]   = (|ovf_set) | state_change;
        flag_set[FLG_WAK]   = wake_evt;
        flag_set[FLG_MERR]  = engine_evt.msg_error;
    end

    // Conditions that still stand keep their flag from being cleared
    always_comb begin
        flag_hold           = flag_set;
        flag_hold[FLG_ERR]  = flag_set[FLG_ERR] | (|ovf_q);
        flag_hold[FLG_WAK]  = flag_set[FLG_WAK] | (sleep_q & engine_evt.bus_activity);
    end

    // Writing zero clears, writing one leaves the flag alone
    assign flag_clr = (wr_commit && sel == SEL_FLAGS) ?
                      ~pwdata[NUM_FLAGS-1:0] : '0;

    generate
        for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_flag
            always_comb begin
                flags_d[g] = flags_q[g];
                if (flag_clr[g] && !flag_hold[g]) begin
                    flags_d[g] = 1'b0;
                end
                if (flag_set[g]) begin
                    flags_d[g] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= ENABLE_RST;
        end else if (wr_commit && sel == SEL_ENABLE) begin
            enable_q <= pwdata[NUM_FLAGS-1:0];
        end
    end

    // Sleep entered by software, left on a wake event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_q <= 1'b0;
        end else if (wake_evt) begin
            sleep_q <= 1'b0;
        end else if (wr_commit && sel == SEL_CTRL) begin
            sleep_q <= pwdata[CTRL_SLEEP];
        end
    end

    // Code and request follow the next flag state, so a clear shows at once
    assign terms_d = flags_d & enable_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q <= CODE_NONE;
            irq_q  <= 1'b0;
        end else begin
            code_q <= encode(terms_d);
            irq_q  <= |terms_d;
        end
    end

    // Protocol error mode
    always_comb begin
        if (err_state.bus_off) begin
            mode_d = MODE_BUSOFF;
        end else if (err_state.rx_passive || err_state.tx_passive) begin
            mode_d = MODE_PASSIVE;
        end else begin
            mode_d = MODE_ACTIVE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_ACTIVE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Read data
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (sel)
            SEL_FLAGS: begin
                rdata_d[NUM_FLAGS-1:0] = flags_q;
            end
            SEL_ENABLE: begin
                rdata_d[NUM_FLAGS-1:0] = enable_q;
            end
            SEL_STATUS: begin
                rdata_d[ST_CODE_LSB +: 3] = code_q;
                rdata_d[ST_IRQ]           = irq_q;
                rdata_d[ST_SLEEP]         = sleep_q;
                rdata_d[ST_MODE_LSB +: 2] = mode_q;
            end
            SEL_COMM: begin
                rdata_d[CS_EWARN]  = err_state.ewarn;
                rdata_d[CS_RXWARN] = err_state.rx_warn;
                rdata_d[CS_TXWARN] = err_state.tx_warn;
                rdata_d[CS_RXPASS] = err_state.rx_passive;
                rdata_d[CS_TXPASS] = err_state.tx_passive;
                rdata_d[CS_BUSOFF] = err_state.bus_off;
                rdata_d[CS_RX1OVF] = ovf_q[1];
                rdata_d[CS_RX0OVF] = ovf_q[0];
            end
            SEL_CTRL: begin
                rdata_d[CTRL_SLEEP] = sleep_q;
            end
            SEL_ERRCNT: begin
                rdata_d[REC_W-1:0]                      = rx_err_cnt;
                rdata_d[ERRCNT_TEC_LSB +: TEC_W]        = tx_err_cnt;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access & ~pready_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr_q <= (sel == SEL_NONE) || (pwrite && sel == SEL_STATUS)
                         || (pwrite && sel == SEL_ERRCNT);
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign irq                 = irq_q;
    assign pending_source_code = code_q;
    assign sleep_mode          = sleep_q;
    assign error_mode          = mode_q;

endmodule
`default_nettype wire

// >>> verification/can_int_sva.sv
// Port-level assertions for the CAN interrupt logic.
// Assumes binding to can_interrupt_logic; shadows ENABLE from committed APB writes.
`timescale 1ns/10ps
`default_nettype none
module can_int_sva
    import can_int_pkg::*;
#(
    parameter int REC_W = 8,
    parameter int TEC_W = 9
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire engine_evt_t      engine_evt,
    input wire logic [REC_W-1:0] rx_err_cnt,
    input wire logic [TEC_W-1:0] tx_err_cnt,
    input wire logic             irq,
    input wire logic [2:0]       pending_source_code,
    input wire logic             sleep_mode,
    input wire err_mode_t        error_mode
);
    logic [7:0] en_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of the enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= ENABLE_RST;
        end else if (psel && penable && pready && pwrite && paddr == OFS_ENABLE) begin
            en_q <= pwdata[7:0];
        end
    end
    chk_rx_irq: assert property (engine_evt.rx_load[0] && en_q[FLG_RX0] |=> irq)
        else $error("rx0 load did not raise irq");
    chk_tx_irq: assert property (engine_evt.tx_empty[1] && en_q[FLG_TX1] |=> irq)
        else $error("tx1 empty did not raise irq");
    chk_merr_irq: assert property (engine_evt.msg_error && en_q[FLG_MERR] |=> irq)
        else $error("message error did not raise irq");
    chk_tx0_top: assert property (engine_evt.tx_empty[0] && en_q[FLG_TX0] && !en_q[FLG_ERR]
        |=> pending_source_code == CODE_TX0)
        else $error("tx0 not top priority");
    chk_code_irq: assert property (pending_source_code != CODE_NONE |-> irq)
        else $error("code pending without irq");
    // Code and irq are built from the enables of the cycle before
    chk_err_code: assert property (pending_source_code == CODE_ERR |-> $past(en_q[FLG_ERR]))
        else $error("error code while disabled");
    chk_irq_masked: assert property ($past(en_q) == 8'h00 |-> !irq)
        else $error("irq with all enables off");
    chk_reset_none: assert property ($rose(presetn) |-> pending_source_code == CODE_NONE && !irq)
        else $error("not idle after reset");
    chk_wake_exit: assert property (sleep_mode && engine_evt.bus_activity && en_q[FLG_WAK]
        |=> !sleep_mode && irq)
        else $error("wake did not exit sleep");
    chk_busoff_mode: assert property ((tx_err_cnt > BUSOFF_LIMIT)[*3] |-> error_mode == MODE_BUSOFF)
        else $error("bus-off not entered");
    chk_passive_mode: assert property ((rx_err_cnt > PASSIVE_LIMIT && tx_err_cnt <= BUSOFF_LIMIT)[*3]
        |-> error_mode == MODE_PASSIVE)
        else $error("error-passive not entered");
    chk_active_mode: assert property ((rx_err_cnt <= PASSIVE_LIMIT && tx_err_cnt <= PASSIVE_LIMIT)[*3]
        |-> error_mode == MODE_ACTIVE)
        else $error("error-active not kept");
    cover property (sleep_mode && engine_evt.bus_activity && en_q[FLG_WAK]);
    cover property (error_mode == MODE_BUSOFF);
    cover property (pending_source_code == CODE_ERR);
endmodule
bind can_interrupt_logic can_int_sva #(.REC_W(REC_W), .TEC_W(TEC_W)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .engine_evt(engine_evt), .rx_err_cnt(rx_err_cnt),
    .tx_err_cnt(tx_err_cnt), .irq(irq), .pending_source_code(pending_source_code),
    .sleep_mode(sleep_mode), .error_mode(error_mode));
`default_nettype wire

// >>> verification/host_model.sv
// Host core model: APB master that services and clears interrupt flags.
// Assumes tasks are entered just after a rising pclk edge.
`timescale 1ns/10ps
`default_nettype none
module host_model
    import can_int_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  pready,
    output logic       psel,
    output logic       penable,
    output logic       pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines do not keep the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // Zero on one flag, ones leave the others alone
    task automatic clear_flag(input int b);
        xfer(1'b1, OFS_FLAGS, ~(32'h0000_0001 << b));
    endtask
    task automatic clear_ovf();
        xfer(1'b1, OFS_COMM, 32'h0000_0000);
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the CAN interrupt logic driven by a host core model.
// Assumes package, design, host model and checker compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import can_int_pkg::*;
;
    localparam logic [32:0] ALL = 33'h1_ffff_ffff;
    localparam int PRI[7] = '{FLG_ERR, FLG_TX0, FLG_TX1, FLG_TX2, FLG_RX0, FLG_RX1, FLG_WAK};
    localparam logic [2:0] PCODE[7] = '{CODE_ERR, CODE_TX0, CODE_TX1, CODE_TX2, CODE_RX0, CODE_RX1, CODE_WAK};
    localparam logic [7:0] REC_TAB[8] = '{8'h60, 8'h5f, 8'h80, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [8:0] TEC_TAB[8] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h060, 9'h080, 9'h100, 9'h0ff};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, irq, sleep_mode;
    logic [7:0]  paddr, fl, en, mc;
    logic [31:0] pwdata, prdata;
    logic [2:0]  code;
    err_mode_t   mode;
    engine_evt_t evt = '0;
    logic [7:0]  rec = 8'h00;
    logic [8:0]  tec = 9'h000;
    logic [32:0] exp_q[$], msk_q[$];
    int          error_cnt = 0;
    int          num_checks = 0;
    always #4 pclk = ~pclk;
    can_interrupt_logic u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .engine_evt(evt),
        .rx_err_cnt(rec), .tx_err_cnt(tec), .irq(irq), .pending_source_code(code), .sleep_mode(sleep_mode),
        .error_mode(mode));
    host_model u_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    function automatic int top(input logic [7:0] t);
        for (int k = 0; k < 7; k++) begin
            if (t[PRI[k]]) return k;
        end
        return 7;
    endfunction
    function automatic logic [32:0] st(input logic [7:0] t, input logic s);
        return {28'h000_0000, s, |t, (top(t) < 7) ? PCODE[top(t)] : CODE_NONE};
    endfunction
    // Mode in [7:6], comm levels in [5:0]
    function automatic logic [7:0] lvl(input logic [7:0] r, input logic [8:0] t);
        logic [5:0] c;
        c[1] = r >= WARN_LIMIT;
        c[2] = t >= WARN_LIMIT;
        c[0] = c[1] | c[2];
        c[3] = r > PASSIVE_LIMIT;
        c[4] = t > PASSIVE_LIMIT;
        c[5] = t > BUSOFF_LIMIT;
        return {c[5] ? 2'h2 : (c[3] | c[4]) ? 2'h1 : 2'h0, c};
    endfunction
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        u_host.xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic pulse(input engine_evt_t v);
        @(posedge pclk);
        evt <= v;
        @(posedge pclk);
        evt <= '0;
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Read checker: oldest note against the answer
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            num_checks++;
            if ((({pslverr, prdata} ^ exp_q[0]) & msk_q[0]) !== 33'h0_0000_0000) begin
                $display("[ERR] read 0x%h expected %h seen %h", paddr, exp_q[0] & msk_q[0],
                         {pslverr, prdata} & msk_q[0]);
                error_cnt++;
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        engine_evt_t v;
        int          k;
        void'($urandom(32'h2821_b37c));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_FLAGS, 33'h0_0000_0000, ALL);
        rd(OFS_ENABLE, 33'h0_0000_0000, ALL);
        rd(OFS_STATUS, 33'h0_0000_0000, ALL);
        rd(8'h18, 33'h1_0000_0000, ALL);
        fl = 8'h00;
        for (int i = 0; i < 8; i++) begin
            en = 8'($urandom_range(255, 0));
            v = '0;
            v.rx_load = 2'($urandom_range(3, 0));
            v.tx_empty = 3'($urandom_range(7, 0));
            v.msg_error = 1'($urandom_range(1, 0));
            u_host.xfer(1'b1, OFS_ENABLE, {24'h00_0000, en});
            pulse(v);
            fl = fl | {v.msg_error, 2'b00, v.tx_empty, v.rx_load};
            rd(OFS_FLAGS, {25'h000_0000, fl}, ALL);
            rd(OFS_STATUS, st(fl & en, 1'b0), ALL);
            k = top(fl & en);
            if (k < 7) begin
                u_host.clear_flag(PRI[k]);
                fl[PRI[k]] = 1'b0;
                rd(OFS_STATUS, st(fl & en, 1'b0), ALL);
            end
        end
        // Overflow raises err; err stays until the overflow is cleared
        u_host.xfer(1'b1, OFS_ENABLE, 32'h0000_0020);
        u_host.xfer(1'b1, OFS_FLAGS, 32'h0000_0000);
        v = '0;
        v.rx_load = 2'b01;
        pulse(v);
        v = '0;
        v.mab_accept = 2'b01;
        pulse(v);
        rd(OFS_COMM, 33'h0_0000_0080, ALL);
        rd(OFS_STATUS, st(8'h20, 1'b0), ALL);
        u_host.xfer(1'b1, OFS_FLAGS, 32'h0000_0000);
        rd(OFS_FLAGS, 33'h0_0000_0020, ALL);
        u_host.clear_ovf();
        u_host.xfer(1'b1, OFS_FLAGS, 32'h0000_0000);
        rd(OFS_FLAGS, 33'h0_0000_0000, ALL);
        for (int i = 0; i < 8; i++) begin
            rec <= REC_TAB[i];
            tec <= TEC_TAB[i];
            repeat (3) @(posedge pclk);
            mc = lvl(REC_TAB[i], TEC_TAB[i]);
            rd(OFS_COMM, {27'h000_0000, mc[5:0]}, ALL);
            rd(OFS_ERRCNT, {1'b0, 7'h00, TEC_TAB[i], 8'h00, REC_TAB[i]}, ALL);
            rd(OFS_STATUS, {26'h000_0000, mc[7:6], 5'h00}, 33'h0_0000_0060);
            rd(OFS_FLAGS, 33'h0_0000_0020, 33'h0_0000_0020);
            u_host.xfer(1'b1, OFS_FLAGS, 32'h0000_0000);
        end
        rec <= 8'h00;
        tec <= 9'h000;
        u_host.xfer(1'b1, OFS_ENABLE, 32'h0000_0040);
        u_host.xfer(1'b1, OFS_CTRL, 32'h0000_0001);
        rd(OFS_STATUS, st(8'h00, 1'b1), ALL);
        evt.bus_activity <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(OFS_STATUS, st(8'h40, 1'b0), ALL);
        evt.bus_activity <= 1'b0;
        u_host.clear_flag(FLG_WAK);
        rd(OFS_FLAGS, 33'h0_0000_0000, 33'h0_0000_0040);
        @(posedge pclk);
        report_and_stop();
    end
endmodule
`default_nettype wire
